// ---- src/srx_dev.sv ----
// Expansion device: serial shift chain, IN/OUT byte memories and processor port
// Function
// - One system clock runs all logic
// - Init reset low gives defined state
// - Init reset held low at least 125 ns
// - Chain steps on shift clock input only
// - Serial input captured on shift clock rise
// - Serial output updates after each clock rise
// - Shift clock forwarded to downstream devices
// - Out strobe copies chain into OUT memory
// - In strobe loads IN memory into chain
// - Register reset clears bus data registers
// - Device sits inside protocol chip data ring
// - Up to six devices cascade clocked serially
// - Strobes and reset fan out in parallel
// - Chip clock output feeds first device
// - Three static pins select chain length
// - Byte data, 4-bit address, strobes, IRQ
// - Separate enables for config, read, write
// - Pins give 0..6 words, 7 undefined
// - Data clears on both resets, config init only
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
module srx_dev
    import srx_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    srx_link_if.dev link,
    input wire logic length_sel_bit0_i,
    input wire logic length_sel_bit1_i,
    input wire logic length_sel_bit2_i,
    input wire logic [3:0] proc_addr_bus_i,
    input wire logic [7:0] proc_data_bus_i,
    output logic [7:0] proc_data_bus_o,
    output logic proc_data_bus_oe_n_o,
    input wire logic proc_rd_n_i,
    input wire logic proc_wr_n_i,
    input wire logic cfg_sel_n_i,
    input wire logic data_read_sel_n_i,
    input wire logic data_write_sel_n_i,
    output logic irq_n_o
);

    // ****************
    // Pin synchronisers
    // ****************
    // All link and processor pins are asynchronous to mclk_i; a link, read/write or length
    // pin level counts once the second and third stage agree, filtering single-cycle glitches.
    logic [NPIN-1:0] pin_w;
    logic [NPIN-1:0] s1_q;
    logic [NPIN-1:0] s2_q;
    logic [NPIN-1:0] s3_q;
    logic [NPIN-1:0] lvl_q;
    logic [NPIN-1:0] prev_q;
    // Address, data and enables ride a two-stage pipe aligned with s2_q
    logic [15:0] bus_w;
    logic [15:0] bus1_q;
    logic [15:0] bus2_q;

    assign pin_w = {link.shift_clk_in_n, link.shift_in, link.out_transfer_strobe,
                    link.in_transfer_strobe_n, link.data_reg_clear_n, proc_rd_n_i,
                    proc_wr_n_i, length_sel_bit2_i, length_sel_bit1_i, length_sel_bit0_i};
    assign bus_w = {data_write_sel_n_i, data_read_sel_n_i, cfg_sel_n_i, proc_addr_bus_i,
                    proc_data_bus_i, 1'b0};

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_q <= PIN_IDLE;
            s2_q <= PIN_IDLE;
            s3_q <= PIN_IDLE;
            lvl_q <= PIN_IDLE;
            prev_q <= PIN_IDLE;
            bus1_q <= '0;
            bus2_q <= '0;
        end else begin
            s1_q <= pin_w;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
            prev_q <= lvl_q;
            bus1_q <= bus_w;
            bus2_q <= bus1_q;
        end
    end

    // ****************
    // Length selection
    // ****************
    logic [2:0] cfg_q;
    logic cfg_set_q;
    logic [2:0] pin_len_w;
    logic [2:0] len_w;
    logic [3:0] nbytes_w;
    logic [6:0] tail_w;

    // Undefined pin pattern falls back to zero words (pass-through)
    assign pin_len_w = (lvl_q[P_K2:P_K0] == LEN_INVALID) ? LEN_ZERO :
                       lvl_q[P_K2:P_K0];
    // A configuration write overrides the pins until the next init reset
    assign len_w = cfg_set_q ? cfg_q : pin_len_w;
    assign nbytes_w = {len_w, 1'b0};
    assign tail_w = 7'({len_w, 4'h0} - 7'h01);

    // ****************
    // Link events
    // ****************
    logic sclk_rise_w;
    logic ostb_rise_w;
    logic load_w;
    logic clear_w;

    assign sclk_rise_w = lvl_q[P_CLK] & ~prev_q[P_CLK];
    assign ostb_rise_w = lvl_q[P_OSTB] & ~prev_q[P_OSTB];
    assign load_w = ~lvl_q[P_ISTB];
    assign clear_w = ~lvl_q[P_CLR];

    // ****************
    // Processor access capture
    // ****************
    logic [3:0] cap_addr_q;
    logic [7:0] cap_data_q;
    logic [2:0] cap_sel_n_q;
    logic wr_low_w;
    logic rd_low_w;
    logic wr_done_w;
    logic rd_done_w;
    logic data_wr_w;
    logic cfg_wr_w;
    logic cfg_touch_w;
    logic rd_sel_w;

    assign wr_low_w = ~s2_q[P_WR] & ~s3_q[P_WR];
    assign rd_low_w = ~s2_q[P_RD] & ~s3_q[P_RD];
    assign wr_done_w = lvl_q[P_WR] & ~prev_q[P_WR];
    assign rd_done_w = lvl_q[P_RD] & ~prev_q[P_RD];
    assign data_wr_w = wr_done_w & ~cap_sel_n_q[2] & (cap_addr_q <= ADDR_LAST_DATA);
    assign cfg_wr_w = wr_done_w & ~cap_sel_n_q[0] & (cap_addr_q == ADDR_CFG);
    assign cfg_touch_w = (wr_done_w | rd_done_w) & ~cap_sel_n_q[0] & (cap_addr_q == ADDR_CFG);
    assign rd_sel_w = (~bus2_q[14] & (bus2_q[12:9] <= ADDR_LAST_DATA)) |
                      (~bus2_q[13] & (bus2_q[12:9] == ADDR_CFG));

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cap_addr_q <= '0;
            cap_data_q <= '0;
            cap_sel_n_q <= '1;
        end else if (wr_low_w || rd_low_w) begin
            cap_addr_q <= bus2_q[12:9];
            cap_data_q <= bus2_q[8:1];
            cap_sel_n_q <= bus2_q[15:13];
        end
    end

    // Config register clears only on the init reset
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_q <= LEN_ZERO;
            cfg_set_q <= 1'b0;
        end else if (cfg_wr_w) begin
            cfg_q <= (cap_data_q[2:0] == LEN_INVALID) ? LEN_ZERO : cap_data_q[2:0];
            cfg_set_q <= 1'b1;
        end
    end

    // ****************
    // Shift chain and byte memories
    // ****************
    logic [CHAIN_BITS-1:0] chain_q;
    logic [CHAIN_BITS-1:0] chain_d;
    logic [7:0] in_mem_q [NBYTES];
    logic [7:0] out_mem_q [NBYTES];
    logic shift_out_q;
    logic clk_out_q;
    logic irq_q;

    // Byte address 0 is the high byte of this device's active section
    always_comb begin
        chain_d = chain_q;
        if (clear_w) begin
            chain_d = '0;
        end else if (load_w) begin
            for (int k = 0; k < NBYTES; k++) begin
                if (4'(k) < nbytes_w) begin
                    chain_d[8*k +: 8] = in_mem_q[4'(nbytes_w - 4'(k) - 4'h1)];
                end
            end
        end else if (sclk_rise_w) begin
            chain_d = {chain_q[CHAIN_BITS-2:0], lvl_q[P_DATA]};
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            chain_q <= '0;
            shift_out_q <= 1'b0;
            clk_out_q <= 1'b1;
        end else begin
            chain_q <= chain_d;
            clk_out_q <= lvl_q[P_CLK];
            // Tail moves only on link events; a new length needs a load
            if (clear_w) begin
                shift_out_q <= 1'b0;
            end else if (len_w == LEN_ZERO) begin
                if (sclk_rise_w) begin
                    shift_out_q <= lvl_q[P_DATA];
                end
            end else if (load_w || sclk_rise_w) begin
                shift_out_q <= chain_d[tail_w];
            end
        end
    end

    generate
        for (genvar a = 0; a < NBYTES; a++) begin : g_byte
            always_ff @(posedge mclk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    in_mem_q[a] <= BYTE_ZERO;
                    out_mem_q[a] <= BYTE_ZERO;
                end else if (clear_w) begin
                    in_mem_q[a] <= BYTE_ZERO;
                    out_mem_q[a] <= BYTE_ZERO;
                end else begin
                    if (data_wr_w && cap_addr_q == 4'(a)) begin
                        in_mem_q[a] <= cap_data_q;
                    end
                    if (ostb_rise_w && 4'(a) < nbytes_w) begin
                        out_mem_q[a] <= chain_q[8*(nbytes_w - 4'(a) - 4'h1) +: 8];
                    end
                end
            end
        end
    endgenerate

    // New OUT data raises the request; any access to the config slot drops it.
    // An event in the same cycle as the drop keeps the request up.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_q <= 1'b0;
        end else if (ostb_rise_w) begin
            irq_q <= 1'b1;
        end else if (cfg_touch_w) begin
            irq_q <= 1'b0;
        end
    end

    // ****************
    // Processor read path
    // ****************
    logic [7:0] rdata_q;
    logic oe_n_q;

    // Drive only after the read is seen steady; release follows the synchroniser
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q <= BYTE_ZERO;
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= ~(rd_low_w & rd_sel_w);
            if (rd_low_w) begin
                rdata_q <= (bus2_q[12:9] <= ADDR_LAST_DATA) ? out_mem_q[bus2_q[12:9]] :
                           {5'h00, len_w};
            end
        end
    end

    assign proc_data_bus_o = rdata_q;
    assign proc_data_bus_oe_n_o = oe_n_q;
    assign irq_n_o = ~irq_q;
    assign link.shift_out = shift_out_q;
    assign link.shift_clk_out_n = clk_out_q;

endmodule

// ---- src/srx_pkg.sv ----
// Shared constants for the serial register expansion block and its protocol-chip end
package srx_pkg;

    // ****************
    // Clock and timing
    // ****************
    localparam int unsigned MCLK_PERIOD_NS = 10;
    // Half period of the shift clock made by the chip end
    localparam int unsigned SCLK_HALF_NS = 80;
    localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    // Width of the transfer and clear strobes made by the chip end
    localparam int unsigned STROBE_NS = 80;
    localparam int unsigned STROBE_CYC = (STROBE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int unsigned TIMER_W = 8;

    // ****************
    // Shift chain geometry
    // ****************
    localparam int unsigned WORD_BITS = 16;
    localparam int unsigned MAX_WORDS = 6;
    localparam int unsigned CHAIN_BITS = WORD_BITS * MAX_WORDS;
    localparam int unsigned NBYTES = 2 * MAX_WORDS;
    localparam logic [2:0] LEN_INVALID = 3'h7;
    localparam logic [2:0] LEN_ZERO = 3'h0;

    // ****************
    // Processor port map
    // ****************
    localparam logic [3:0] ADDR_CFG = 4'hC;
    localparam logic [3:0] ADDR_LAST_DATA = 4'hB;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ****************
    // Synchronised pin positions inside the device
    // ****************
    localparam int unsigned NPIN = 10;
    localparam int unsigned P_K0 = 0;
    localparam int unsigned P_K2 = 2;
    localparam int unsigned P_WR = 3;
    localparam int unsigned P_RD = 4;
    localparam int unsigned P_CLR = 5;
    localparam int unsigned P_ISTB = 6;
    localparam int unsigned P_OSTB = 7;
    localparam int unsigned P_DATA = 8;
    localparam int unsigned P_CLK = 9;
    // Idle levels: clock, in/clear strobes and write/read high; out strobe and data low
    localparam logic [NPIN-1:0] PIN_IDLE = 10'h278;

    // ****************
    // Chip end Avalon-MM register map (byte addresses)
    // ****************
    localparam int unsigned AV_AW = 5;
    localparam logic [AV_AW-1:0] REG_CTRL = 5'h00;
    localparam logic [AV_AW-1:0] REG_COUNT = 5'h04;
    localparam logic [AV_AW-1:0] REG_DATA0 = 5'h08;
    localparam logic [AV_AW-1:0] REG_DATA1 = 5'h0C;
    localparam logic [AV_AW-1:0] REG_DATA2 = 5'h10;
    localparam int unsigned CTRL_GO = 0;
    localparam int unsigned CTRL_OSTB = 1;
    localparam int unsigned CTRL_ISTB = 2;
    localparam int unsigned CTRL_CLR = 3;
    localparam int unsigned COUNT_W = 7;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 7'h60;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LOW = 4'h2,
        ST_HIGH = 4'h4,
        ST_STRB = 4'h8
    } srx_state_t;

endpackage

// ---- src/srx_link_if.sv ----
// Serial ring wiring between the protocol-chip end and one expansion device
`timescale 1ns/1ps
interface srx_link_if;
    logic shift_in;
    logic shift_out;
    logic shift_clk_in_n;
    logic shift_clk_out_n;
    logic out_transfer_strobe;
    logic in_transfer_strobe_n;
    logic data_reg_clear_n;

    modport dev (
        input shift_in,
        input shift_clk_in_n,
        input out_transfer_strobe,
        input in_transfer_strobe_n,
        input data_reg_clear_n,
        output shift_out,
        output shift_clk_out_n
    );

    modport chip (
        output shift_in,
        output shift_clk_in_n,
        output out_transfer_strobe,
        output in_transfer_strobe_n,
        output data_reg_clear_n,
        input shift_out
    );
endinterface

// ---- src/srx_chip.sv ----
// Protocol-chip end: drives the shift clock, data and strobes under Avalon-MM control
`timescale 1ns/1ps
module srx_chip
    import srx_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    srx_link_if.chip link,
    input wire logic [AV_AW-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);

    // ****************
    // Return data synchroniser
    // ****************
    logic sin1_q;
    logic sin2_q;
    logic sin3_q;
    logic sin_q;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sin1_q <= 1'b0;
            sin2_q <= 1'b0;
            sin3_q <= 1'b0;
            sin_q <= 1'b0;
        end else begin
            sin1_q <= link.shift_out;
            sin2_q <= sin1_q;
            sin3_q <= sin2_q;
            if (sin2_q == sin3_q) begin
                sin_q <= sin3_q;
            end
        end
    end

    // ****************
    // Avalon-MM slave: one wait cycle, then the access completes
    // ****************
    logic ack_q;
    logic req_w;
    logic wr_w;
    logic busy_w;
    logic [31:0] rdata_q;
    srx_state_t state_q;
    logic [CHAIN_BITS-1:0] shreg_q;
    logic [COUNT_W-1:0] count_q;

    assign req_w = avs_read_i | avs_write_i;
    assign wr_w = avs_write_i & ack_q;
    assign busy_w = (state_q != ST_IDLE);
    assign avs_waitrequest_o = req_w & ~ack_q;
    assign avs_readdata_o = rdata_q;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= req_w & ~ack_q;
            unique case (avs_address_i)
                REG_CTRL: rdata_q <= {31'h0, busy_w};
                REG_COUNT: rdata_q <= {25'h0, count_q};
                REG_DATA0: rdata_q <= shreg_q[31:0];
                REG_DATA1: rdata_q <= shreg_q[63:32];
                REG_DATA2: rdata_q <= shreg_q[95:64];
                default: rdata_q <= '0;
            endcase
        end
    end

    // ****************
    // Link sequencer
    // ****************
    // Data changes on the falling clock edge and the return bit is taken
    // on the rising edge, so both sides see stable data across the edge.
    logic [TIMER_W-1:0] timer_q;
    logic [COUNT_W-1:0] left_q;
    logic clk_n_q;
    logic dout_q;
    logic ostb_q;
    logic istb_n_q;
    logic clr_n_q;
    logic go_w;
    logic strb_w;

    assign go_w = wr_w && avs_address_i == REG_CTRL && !busy_w;
    assign strb_w = avs_writedata_i[CTRL_OSTB] | avs_writedata_i[CTRL_ISTB] |
                    avs_writedata_i[CTRL_CLR];

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_q <= '0;
        end else if (wr_w && avs_address_i == REG_COUNT) begin
            count_q <= (avs_writedata_i[COUNT_W-1:0] > COUNT_MAX) ? COUNT_MAX :
                       avs_writedata_i[COUNT_W-1:0];
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
            timer_q <= '0;
            left_q <= '0;
            shreg_q <= '0;
            clk_n_q <= 1'b1;
            dout_q <= 1'b0;
            ostb_q <= 1'b0;
            istb_n_q <= 1'b1;
            clr_n_q <= 1'b1;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (wr_w && !busy_w && avs_address_i == REG_DATA0) begin
                        shreg_q[31:0] <= avs_writedata_i;
                    end
                    if (wr_w && !busy_w && avs_address_i == REG_DATA1) begin
                        shreg_q[63:32] <= avs_writedata_i;
                    end
                    if (wr_w && !busy_w && avs_address_i == REG_DATA2) begin
                        shreg_q[95:64] <= avs_writedata_i;
                    end
                    if (go_w && avs_writedata_i[CTRL_GO] && count_q != '0) begin
                        state_q <= ST_LOW;
                        left_q <= count_q;
                        clk_n_q <= 1'b0;
                        dout_q <= shreg_q[CHAIN_BITS-1];
                        timer_q <= TIMER_W'(SCLK_HALF_CYC - 1);
                    end else if (go_w && strb_w) begin
                        state_q <= ST_STRB;
                        ostb_q <= avs_writedata_i[CTRL_OSTB];
                        istb_n_q <= ~avs_writedata_i[CTRL_ISTB];
                        clr_n_q <= ~avs_writedata_i[CTRL_CLR];
                        timer_q <= TIMER_W'(STROBE_CYC - 1);
                    end
                end
                ST_LOW: begin
                    if (timer_q != '0) begin
                        timer_q <= timer_q - 1'b1;
                    end else begin
                        state_q <= ST_HIGH;
                        clk_n_q <= 1'b1;
                        shreg_q <= {shreg_q[CHAIN_BITS-2:0], sin_q};
                        left_q <= left_q - 1'b1;
                        timer_q <= TIMER_W'(SCLK_HALF_CYC - 1);
                    end
                end
                ST_HIGH: begin
                    if (timer_q != '0) begin
                        timer_q <= timer_q - 1'b1;
                    end else if (left_q == '0) begin
                        state_q <= ST_IDLE;
                    end else begin
                        state_q <= ST_LOW;
                        clk_n_q <= 1'b0;
                        dout_q <= shreg_q[CHAIN_BITS-1];
                        timer_q <= TIMER_W'(SCLK_HALF_CYC - 1);
                    end
                end
                ST_STRB: begin
                    if (timer_q != '0) begin
                        timer_q <= timer_q - 1'b1;
                    end else begin
                        state_q <= ST_IDLE;
                        ostb_q <= 1'b0;
                        istb_n_q <= 1'b1;
                        clr_n_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign link.shift_in = dout_q;
    assign link.shift_clk_in_n = clk_n_q;
    assign link.out_transfer_strobe = ostb_q;
    assign link.in_transfer_strobe_n = istb_n_q;
    assign link.data_reg_clear_n = clr_n_q;

endmodule

// ---- tb/srx_link_props.sv ----
// Concurrent checks on the serial ring between the chip end and the device
`timescale 1ns/1ps
module srx_link_props (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic shift_in,
    input wire logic shift_out,
    input wire logic shift_clk_in_n,
    input wire logic shift_clk_out_n,
    input wire logic out_transfer_strobe,
    input wire logic in_transfer_strobe_n,
    input wire logic data_reg_clear_n
);
    // ****************
    // Helper logic
    // ****************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    // Cycles since a clock low, in strobe or clear strobe; the tail may move only shortly after one
    logic [4:0] evt_q;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) evt_q <= 5'h1F;
        else if (!shift_clk_in_n || !in_transfer_strobe_n || !data_reg_clear_n) evt_q <= 5'h00;
        else if (evt_q != 5'h1F) evt_q <= evt_q + 5'h01;
    end
    // ****************
    // Properties
    // ****************
    property p_fwd_rise; $rose(shift_clk_in_n) |-> ##[2:8] $rose(shift_clk_out_n); endproperty
    a_fwd_rise: assert property (p_fwd_rise) else $error("clock out missed a rise");
    property p_fwd_idle; shift_clk_in_n [*8] |-> shift_clk_out_n; endproperty
    a_fwd_idle: assert property (p_fwd_idle) else $error("clock out low while idle");
    property p_tail; $changed(shift_out) |-> evt_q <= 5'h0A; endproperty
    a_tail: assert property (p_tail) else $error("serial out moved without a cause");
    property p_clr; $fell(data_reg_clear_n) |-> ##8 !shift_out; endproperty
    a_clr: assert property (p_clr) else $error("serial out not cleared");
    property p_low; $fell(shift_clk_in_n) |-> !shift_clk_in_n [*8] ##1 shift_clk_in_n; endproperty
    a_low: assert property (p_low) else $error("shift clock low phase wrong");
    property p_hold; !$past(shift_clk_in_n) |-> $stable(shift_in); endproperty
    a_hold: assert property (p_hold) else $error("serial data moved near a rise");
    property p_ostb; $rose(out_transfer_strobe) |->
        out_transfer_strobe [*8] ##1 !out_transfer_strobe;
    endproperty
    a_ostb: assert property (p_ostb) else $error("out strobe width wrong");
    property p_sep; !in_transfer_strobe_n || out_transfer_strobe || !data_reg_clear_n
        |-> shift_clk_in_n;
    endproperty
    a_sep: assert property (p_sep) else $error("strobe overlaps shifting");
    cover property ($fell(in_transfer_strobe_n));
    cover property ($rose(out_transfer_strobe));
    cover property ($fell(data_reg_clear_n));
endmodule

// ---- tb/tb_serial_register_expansion.sv ----
// Bench joining the chip end and the expansion device across the serial ring
`timescale 1ns/1ps
module tb_serial_register_expansion;
    import srx_pkg::*;
    // ****************
    // Signals and instances
    // ****************
    logic mclk_i = 1'h0;
    logic resetn_i = 1'h0;
    logic av_rd = 1'h0, av_wr = 1'h0, wreq, poe_n, irq_n;
    logic [4:0] av_a = 5'h00;
    logic [31:0] av_d = 32'h0, rdata;
    logic [2:0] lsel = 3'h0;
    logic [3:0] pa = 4'h0;
    logic [7:0] pd = 8'h00, pq;
    logic rd_n = 1'h1, wr_n = 1'h1, cfg_n = 1'h1, drs_n = 1'h1, dws_n = 1'h1;
    int mismatches = 0, cmp_count = 0, cyc = 0;
    srx_link_if srx_link_if_inst ();
    srx_chip srx_chip_inst (.mclk_i(mclk_i), .resetn_i(resetn_i), .link(srx_link_if_inst),
        .avs_address_i(av_a), .avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_d),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq));
    srx_dev srx_dev_inst (.mclk_i(mclk_i), .resetn_i(resetn_i), .link(srx_link_if_inst),
        .length_sel_bit0_i(lsel[0]), .length_sel_bit1_i(lsel[1]), .length_sel_bit2_i(lsel[2]),
        .proc_addr_bus_i(pa), .proc_data_bus_i(pd), .proc_data_bus_o(pq),
        .proc_data_bus_oe_n_o(poe_n), .proc_rd_n_i(rd_n), .proc_wr_n_i(wr_n), .cfg_sel_n_i(cfg_n),
        .data_read_sel_n_i(drs_n), .data_write_sel_n_i(dws_n), .irq_n_o(irq_n));
    srx_link_props srx_link_props_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .shift_in(srx_link_if_inst.shift_in), .shift_out(srx_link_if_inst.shift_out),
        .shift_clk_in_n(srx_link_if_inst.shift_clk_in_n),
        .shift_clk_out_n(srx_link_if_inst.shift_clk_out_n),
        .out_transfer_strobe(srx_link_if_inst.out_transfer_strobe),
        .in_transfer_strobe_n(srx_link_if_inst.in_transfer_strobe_n),
        .data_reg_clear_n(srx_link_if_inst.data_reg_clear_n));
    initial forever #5 mclk_i = ~mclk_i;
    // ****************
    // Tasks
    // ****************
    task automatic chk(input string nm, input logic [95:0] s, input logic [95:0] e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    function automatic logic [95:0] ring_exp(input logic [95:0] o, ic, input int n);
        return (o << n) | ic;
    endfunction
    // Request held until waitrequest is seen low at a rising edge
    task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d,
        output logic [31:0] q);
        av_a <= a;
        av_d <= d;
        av_wr <= w;
        av_rd <= !w;
        @(posedge mclk_i);
        while (wreq !== 1'h0) @(posedge mclk_i);
        q = rdata;
        av_wr <= 1'h0;
        av_rd <= 1'h0;
        @(posedge mclk_i);
    endtask
    // Pulse one control bit, then wait for the chip to go idle and the device to act
    task automatic ctrl(input int bitpos);
        logic [31:0] q;
        av(1'h1, REG_CTRL, 32'h1 << bitpos, q);
        q = 32'h1;
        while (q[CTRL_GO] !== 1'h0) av(1'h0, REG_CTRL, 32'h0, q);
        repeat (12) @(posedge mclk_i);
    endtask
    // Select stays valid a few cycles around the strobe, since pins are synchronised
    task automatic pacc(input logic w, input logic c, input logic [3:0] a, input logic [7:0] d,
        output logic [7:0] q);
        pa <= a;
        pd <= d;
        cfg_n <= !c;
        dws_n <= c || !w;
        drs_n <= c || w;
        @(posedge mclk_i);
        wr_n <= !w;
        rd_n <= w;
        repeat (5) @(posedge mclk_i);
        @(negedge mclk_i);
        q = pq;
        if (!w) chk("data bus enable", poe_n, 96'h0);
        @(posedge mclk_i);
        wr_n <= 1'h1;
        rd_n <= 1'h1;
        repeat (4) @(posedge mclk_i);
        {cfg_n, dws_n, drs_n} <= 3'h7;
        repeat (2) @(posedge mclk_i);
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        logic [95:0] o, ic, got;
        logic [31:0] q;
        logic [7:0] b, r;
        void'($urandom(26));
        repeat (3) @(posedge mclk_i);
        resetn_i <= 1'h1;
        repeat (4) @(posedge mclk_i);
        pacc(1'h0, 1'h0, 4'h0, 8'h00, r);
        chk("out byte after reset", r, 96'h0);
        chk("irq after reset", irq_n, 96'h1);
        av(1'h0, 5'h14, 32'h0, q);
        chk("unmapped read", q, 96'h0);
        for (int l = 1; l <= 6; l++) begin
            lsel <= (l > 3) ? 3'($urandom_range(6)) : 3'(l);
            if (l > 3) pacc(1'h1, 1'h1, ADDR_CFG, 8'(l), r);
            ic = '0;
            for (int a = 0; a < 2 * l; a++) begin
                b = 8'($urandom);
                ic = {ic[87:0], b};
                pacc(1'h1, 1'h0, 4'(a), b, r);
            end
            ctrl(CTRL_ISTB);
            o = {$urandom, $urandom, $urandom};
            av(1'h1, REG_DATA0, o[31:0], q);
            av(1'h1, REG_DATA1, o[63:32], q);
            av(1'h1, REG_DATA2, o[95:64], q);
            av(1'h1, REG_COUNT, 32'(16 * l), q);
            ctrl(CTRL_GO);
            av(1'h0, REG_DATA0, 32'h0, got[31:0]);
            av(1'h0, REG_DATA1, 32'h0, got[63:32]);
            av(1'h0, REG_DATA2, 32'h0, got[95:64]);
            chk("ring words", got, ring_exp(o, ic, 16 * l));
            ctrl(CTRL_OSTB);
            chk("irq after out strobe", irq_n, 96'h0);
            for (int a = 0; a < 2 * l; a++) begin
                pacc(1'h0, 1'h0, 4'(a), 8'h00, r);
                chk("out byte", r, o[95 - 8 * a -: 8]);
            end
            pacc(1'h0, 1'h1, ADDR_CFG, 8'h00, r);
            chk("length", r[2:0], 96'(l));
            chk("irq cleared", irq_n, 96'h1);
        end
        ctrl(CTRL_CLR);
        pacc(1'h0, 1'h0, 4'h0, 8'h00, r);
        chk("out byte after clear", r, 96'h0);
        pacc(1'h0, 1'h1, ADDR_CFG, 8'h00, r);
        chk("length kept", r[2:0], 96'h6);
        lsel <= 3'h7;
        resetn_i <= 1'h0;
        repeat (13) @(posedge mclk_i);
        resetn_i <= 1'h1;
        repeat (4) @(posedge mclk_i);
        pacc(1'h0, 1'h1, ADDR_CFG, 8'h00, r);
        chk("length after init reset", r[2:0], 96'h0);
        print_verdict();
    end
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            print_verdict();
        end
    end
endmodule
